/* File: design/cdu_pkg.sv */
package cdu_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_UPDATE_CONTROL = 8'h90;
    localparam logic [7:0] REG_USER_DOWNLOAD  = 8'hd8;
    localparam logic [7:0] REG_MANUFACTURER   = 8'hf4;
    localparam logic [7:0] REG_SILICON_REV    = 8'hf5;
    localparam logic [7:0] REG_BRAND_FIRST    = 8'hf6;
    localparam logic [7:0] REG_BRAND_SECOND   = 8'hf7;
    localparam logic [7:0] NV_HIGH_FIRST      = 8'hf8;
    localparam logic [7:0] NV_HIGH_LAST       = 8'hfb;
    localparam logic [7:0] CMD_PAGE_ERASE     = 8'hfe;
    localparam logic [7:0] RESET_UPDATE_CTRL  = 8'h00;
    localparam logic [7:0] ERASED_BYTE        = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int UPD_TRANSPARENT_BIT = 0;
    localparam int UPD_COMMIT_BIT      = 1;
    localparam int UPD_ERASE_EN_BIT    = 2;
    localparam int UDL_REQUEST_BIT     = 0;
    localparam int NV_CELL_SEL_BIT     = 9;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          RAM_BYTES     = 224;
    localparam logic [7:0]  RAM_LAST      = 8'hdf;
    localparam int          NV_CELL_BYTES = 512;
    localparam int          PAGE_BYTES    = 32;
    localparam int          SE_STATES     = 64;
    localparam int          STATE_BITS    = 64;
    localparam logic [5:0]  SE_LAST_USABLE = 6'h3e;
    localparam logic [4:0]  SLAVE_ADDR_UPPER = 5'b01101;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 4;
    localparam int SE_START_NS     = 500000;
    localparam int SE_FETCH_NS     = 10000;
    localparam int SE_START_CYCLES = SE_START_NS / CLK_PERIOD_NS;
    localparam int SE_FETCH_CYCLES =
        (SE_FETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Loader sequence, one-hot
    typedef enum logic [4:0] {
        ST_LOCKOUT = 5'b00001,
        ST_FILL    = 5'b00010,
        ST_COMMIT  = 5'b00100,
        ST_SE_WAIT = 5'b01000,
        ST_RUN     = 5'b10000
    } cdu_state_type;

endpackage

/* File: design/cdu_top.sv */
// How it works
// - Download starts only above undervoltage lockout
// - Fill all staging latches, then commit together
// - First engine state fetch starts 0.5 ms later
// - No bus acknowledge before power-up download completes
// - Transparent bit makes writes take effect now
// - Staged mode writes only the staging latch
// - Commit bit copies all staging latches at once
// - Nonvolatile edits leave working latches untouched
// - Page erase only while erase enable set
// - User download bit reloads pages 0 to 6
// - Engine store: 63 usable 64-bit states
// - Next state fetched on advance, about 10 us
// - First written byte, unless 0xFE, loads the address pointer
// - Nonvolatile store mapped at 0xF800 to 0xFBFF
// - Program only blank bytes; erase page first
// - 16 pages of 32 bytes, pages 0-6 mirror RAM
// - Slave address 01101 plus two select pins
// - Four read-only identification bytes
// - Erase enable is update control bit 2
module cdu_top
    import cdu_pkg::*;
#(
    parameter int unsigned SE_START_DELAY = SE_START_CYCLES,
    parameter logic [7:0]  ID_MANUFACTURER = 8'h5a, // Arbitrary value
    parameter logic [7:0]  ID_REVISION     = 8'h11, // Arbitrary value
    parameter logic [7:0]  ID_BRAND_FIRST  = 8'h3c, // Arbitrary value
    parameter logic [7:0]  ID_BRAND_SECOND = 8'hc3  // Arbitrary value
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_supply_ok,
    input  wire logic        i_addr_select_high,
    input  wire logic        i_addr_select_low,
    input  wire logic        i_bus_addr_valid,
    input  wire logic [6:0]  i_bus_addr,
    input  wire logic        i_bus_rnw,
    input  wire logic        i_bus_wr_valid,
    input  wire logic [7:0]  i_bus_wr_data,
    input  wire logic        i_bus_rd_req,
    input  wire logic        i_bus_stop,
    input  wire logic [7:0]  i_cfg_index,
    input  wire logic        i_se_advance,
    input  wire logic [5:0]  i_se_next_state,
    output logic             o_bus_ack,
    output logic             o_bus_rd_valid,
    output logic [7:0]       o_bus_rd_data,
    output logic [7:0]       o_cfg_data,
    output logic             o_cfg_ready,
    output logic             o_se_load,
    output logic [63:0]      o_se_state_word
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] nv_cfg_q  [NV_CELL_BYTES];
    logic [7:0] nv_se_q   [NV_CELL_BYTES];
    logic [7:0] staging_q [RAM_BYTES];
    logic [7:0] active_q  [RAM_BYTES];

    cdu_state_type state_q;
    logic [7:0]  fill_idx_q;
    logic        powerup_q;
    logic [31:0] se_wait_q;
    logic [7:0]  update_ctrl_q;
    logic        udl_req_q;
    logic [7:0]  ptr_q;
    logic [7:0]  nv_hi_q;
    logic [7:0]  nv_lo_q;
    logic        sel_q;
    logic        first_q;
    logic        lo_pend_q;
    logic        se_busy_q;
    logic [11:0] se_cnt_q;
    logic [5:0]  se_idx_q;

    // Nonvolatile window test, used by pointer and read paths
    function automatic logic is_nv_high(input logic [7:0] b);
        return (b >= NV_HIGH_FIRST) && (b <= NV_HIGH_LAST);
    endfunction

    // ------------------------------------------------------------
    // Bus strobes
    // ------------------------------------------------------------
    logic       ready;
    logic       addr_hit;
    logic       wr_fire;
    logic       data_wr;
    logic       nv_wr;
    logic       ram_wr;
    logic       ctrl_wr;
    logic       udl_wr;
    logic       erase_cmd;
    logic       erase_fire;
    logic       commit_all;
    logic [9:0] nv_addr;

    assign ready    = (state_q == ST_SE_WAIT) || (state_q == ST_RUN) ||
                      (!powerup_q && state_q != ST_LOCKOUT);
    assign addr_hit = i_bus_addr == {SLAVE_ADDR_UPPER, i_addr_select_high,
                                     i_addr_select_low};
    assign wr_fire  = i_bus_wr_valid && sel_q && ready;
    assign data_wr  = wr_fire && !first_q && !lo_pend_q;
    assign nv_wr    = data_wr && is_nv_high(nv_hi_q) &&
                      is_nv_high(ptr_q);
    assign ctrl_wr  = data_wr && ptr_q == REG_UPDATE_CONTROL;
    assign udl_wr   = data_wr && ptr_q == REG_USER_DOWNLOAD;
    assign ram_wr   = data_wr && ptr_q <= RAM_LAST && !ctrl_wr && !udl_wr;
    assign erase_cmd = wr_fire && first_q &&
                       i_bus_wr_data == CMD_PAGE_ERASE;
    assign erase_fire = erase_cmd &&
                        update_ctrl_q[UPD_ERASE_EN_BIT];
    assign commit_all = (state_q == ST_COMMIT) ||
                        (ctrl_wr && i_bus_wr_data[UPD_COMMIT_BIT]);
    assign nv_addr  = {nv_hi_q[1:0], nv_lo_q};

    // ------------------------------------------------------------
    // Loader sequence
    // ------------------------------------------------------------
    // Lockout holds until supply is good; then fill, commit, wait
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q    <= ST_LOCKOUT;
            fill_idx_q <= 8'h00;
            powerup_q  <= 1'b1;
            se_wait_q  <= 32'h0000_0000;
        end else begin
            case (state_q)
                ST_LOCKOUT: begin
                    if (i_supply_ok) begin
                        state_q <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    fill_idx_q <= fill_idx_q + 8'h01;
                    if (fill_idx_q == RAM_LAST) begin
                        state_q <= ST_COMMIT;
                    end
                end
                ST_COMMIT: begin
                    fill_idx_q <= 8'h00;
                    state_q    <= powerup_q ? ST_SE_WAIT : ST_RUN;
                end
                ST_SE_WAIT: begin
                    powerup_q <= 1'b0;
                    se_wait_q <= se_wait_q + 32'h0000_0001;
                    if (se_wait_q == 32'(SE_START_DELAY - 1)) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (udl_req_q) begin
                        state_q <= ST_FILL;
                    end
                end
                default: begin
                    state_q <= ST_LOCKOUT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Commit bit is a strobe and never stored
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            update_ctrl_q <= RESET_UPDATE_CTRL;
        end else if (ctrl_wr) begin
            update_ctrl_q <= i_bus_wr_data & ~(8'h01 << UPD_COMMIT_BIT);
        end
    end

    // Request bit: a new write wins over the self-clear
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            udl_req_q <= 1'b0;
        end else if (udl_wr && i_bus_wr_data[UDL_REQUEST_BIT]) begin
            udl_req_q <= 1'b1;
        end else if (state_q == ST_COMMIT && !powerup_q) begin
            udl_req_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pointer and session tracking
    // ------------------------------------------------------------
    // A high byte of F8..FB expects a low address byte next
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ptr_q     <= 8'h00;
            nv_hi_q   <= 8'h00;
            nv_lo_q   <= 8'h00;
            sel_q     <= 1'b0;
            first_q   <= 1'b0;
            lo_pend_q <= 1'b0;
        end else begin
            if (i_bus_stop) begin
                sel_q     <= 1'b0;
                lo_pend_q <= 1'b0;
            end else if (i_bus_addr_valid) begin
                sel_q   <= addr_hit && ready;
                first_q <= !i_bus_rnw;
            end else if (wr_fire && first_q) begin
                first_q <= 1'b0;
                if (i_bus_wr_data != CMD_PAGE_ERASE) begin
                    ptr_q <= i_bus_wr_data;
                end
                if (is_nv_high(i_bus_wr_data)) begin
                    nv_hi_q   <= i_bus_wr_data;
                    lo_pend_q <= 1'b1;
                end
            end else if (wr_fire && lo_pend_q) begin
                nv_lo_q   <= i_bus_wr_data;
                lo_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Nonvolatile cells
    // ------------------------------------------------------------
    // No reset: contents persist; program only blank bytes
    always_ff @(posedge i_clk_sys) begin
        if (nv_wr && !nv_hi_q[1]) begin
            if (nv_cfg_q[nv_addr[8:0]] == ERASED_BYTE) begin
                nv_cfg_q[nv_addr[8:0]] <= i_bus_wr_data;
            end
        end
        if (erase_fire && !nv_hi_q[1]) begin
            for (int k = 0; k < PAGE_BYTES; k++) begin
                nv_cfg_q[{nv_addr[8:5], 5'(k)}] <= ERASED_BYTE;
            end
        end
    end

    // Engine cell, host edits state words here directly
    always_ff @(posedge i_clk_sys) begin
        if (nv_wr && nv_hi_q[1]) begin
            if (nv_se_q[nv_addr[8:0]] == ERASED_BYTE) begin
                nv_se_q[nv_addr[8:0]] <= i_bus_wr_data;
            end
        end
        if (erase_fire && nv_hi_q[1]) begin
            for (int k = 0; k < PAGE_BYTES; k++) begin
                nv_se_q[{nv_addr[8:5], 5'(k)}] <= ERASED_BYTE;
            end
        end
    end

    // ------------------------------------------------------------
    // Double-buffered latches
    // ------------------------------------------------------------
    // Download takes the staging port over bus writes
    always_ff @(posedge i_clk_sys) begin
        if (state_q == ST_FILL) begin
            staging_q[fill_idx_q] <= nv_cfg_q[{1'b0, fill_idx_q}];
        end else if (ram_wr) begin
            staging_q[ptr_q] <= i_bus_wr_data;
        end
    end

    // One wide copy keeps all functions switching together
    always_ff @(posedge i_clk_sys) begin
        if (commit_all) begin
            for (int k = 0; k < RAM_BYTES; k++) begin
                active_q[k] <= staging_q[k];
            end
        end else if (ram_wr && update_ctrl_q[UPD_TRANSPARENT_BIT]) begin
            active_q[ptr_q] <= i_bus_wr_data;
        end
    end

    // Function-side view of the working latches
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cfg_data  <= 8'h00;
            o_cfg_ready <= 1'b0;
        end else begin
            o_cfg_data  <= (i_cfg_index <= RAM_LAST) ?
                           active_q[i_cfg_index] : 8'h00;
            o_cfg_ready <= ready;
        end
    end

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    // Read returns staging bytes, so staged edits can be checked
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bus_ack      <= 1'b0;
            o_bus_rd_valid <= 1'b0;
            o_bus_rd_data  <= 8'h00;
        end else begin
            o_bus_ack <= (i_bus_addr_valid && addr_hit && ready) ||
                         wr_fire;
            o_bus_rd_valid <= i_bus_rd_req && sel_q && ready;
            if (is_nv_high(ptr_q)) begin
                o_bus_rd_data <= nv_hi_q[1] ? nv_se_q[nv_addr[8:0]]
                                            : nv_cfg_q[nv_addr[8:0]];
            end else begin
                case (ptr_q)
                    REG_UPDATE_CONTROL: o_bus_rd_data <= update_ctrl_q;
                    REG_USER_DOWNLOAD:  o_bus_rd_data <= {7'h00, udl_req_q};
                    REG_MANUFACTURER:   o_bus_rd_data <= ID_MANUFACTURER;
                    REG_SILICON_REV:    o_bus_rd_data <= ID_REVISION;
                    REG_BRAND_FIRST:    o_bus_rd_data <= ID_BRAND_FIRST;
                    REG_BRAND_SECOND:   o_bus_rd_data <= ID_BRAND_SECOND;
                    default: begin
                        o_bus_rd_data <= (ptr_q <= RAM_LAST) ?
                                         staging_q[ptr_q] : 8'h00;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencing engine fetch
    // ------------------------------------------------------------
    // Advance requests during a fetch or to the reserved state drop
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            se_busy_q       <= 1'b0;
            se_cnt_q        <= 12'h000;
            se_idx_q        <= 6'h00;
            o_se_load       <= 1'b0;
            o_se_state_word <= 64'h0;
        end else begin
            o_se_load <= 1'b0;
            if (se_busy_q) begin
                se_cnt_q <= se_cnt_q + 12'h001;
                if (se_cnt_q == 12'(SE_FETCH_CYCLES - 1)) begin
                    se_busy_q <= 1'b0;
                    o_se_load <= 1'b1;
                    for (int k = 0; k < STATE_BITS / 8; k++) begin
                        o_se_state_word[k*8 +: 8] <=
                            nv_se_q[{se_idx_q, 3'(k)}];
                    end
                end
            end else if (state_q == ST_SE_WAIT &&
                         se_wait_q == 32'(SE_START_DELAY - 1)) begin
                se_busy_q <= 1'b1;
                se_cnt_q  <= 12'h000;
                se_idx_q  <= 6'h00;
            end else if (state_q == ST_RUN && i_se_advance &&
                         i_se_next_state <= SE_LAST_USABLE) begin
                se_busy_q <= 1'b1;
                se_cnt_q  <= 12'h000;
                se_idx_q  <= i_se_next_state;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cdu_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    a_lockout_hold: assert property (
        state_q == ST_LOCKOUT && !i_supply_ok |=> state_q == ST_LOCKOUT)
        else $error("download left lockout with supply low");

    // Cells never programmed hold no defined value, hence case equality
    a_fill_then_commit: assert property (
        state_q == ST_FILL && fill_idx_q == RAM_LAST
        |=> state_q == ST_COMMIT ##1 active_q[0] === $past(staging_q[0]))
        else $error("commit did not follow last staging fill");

    a_se_start_delay: assert property (
        state_q == ST_SE_WAIT && se_wait_q == 32'(SE_START_DELAY - 1)
        |=> se_busy_q && se_idx_q == 6'h00)
        else $error("first engine state fetch not started on time");

    a_early_nack: assert property (
        i_bus_addr_valid && !ready |=> !o_bus_ack)
        else $error("acknowledge given before download done");

    a_wrong_addr: assert property (
        i_bus_addr_valid && i_bus_addr[6:2] != SLAVE_ADDR_UPPER
        |=> !o_bus_ack)
        else $error("acknowledge to foreign slave address");

    a_staged_hold: assert property (
        ram_wr && !update_ctrl_q[UPD_TRANSPARENT_BIT] && !commit_all
        |=> active_q[$past(ptr_q)] == $past(active_q[ptr_q]))
        else $error("staged write changed active latch");

    a_transparent_wr: assert property (
        ram_wr && update_ctrl_q[UPD_TRANSPARENT_BIT] && !commit_all
        |=> active_q[$past(ptr_q)] == $past(i_bus_wr_data))
        else $error("transparent write not applied");

    // Watches the stored byte, not the gate term itself
    a_erase_gated: assert property (
        erase_cmd && !update_ctrl_q[UPD_ERASE_EN_BIT] && !nv_hi_q[1]
        |=> nv_cfg_q[nv_addr[8:0]] == $past(nv_cfg_q[nv_addr[8:0]]))
        else $error("page erased without erase enable");

    a_udl_clears: assert property (
        state_q == ST_COMMIT && !powerup_q && !udl_wr |=> !udl_req_q)
        else $error("user download bit did not clear");

    a_pointer_load: assert property (
        wr_fire && first_q && i_bus_wr_data != CMD_PAGE_ERASE && !i_bus_stop
        && !i_bus_addr_valid |=> ptr_q == $past(i_bus_wr_data))
        else $error("first byte not loaded into pointer");

    c_powerup_done: cover property (
        state_q == ST_SE_WAIT ##1 state_q == ST_RUN);
    c_user_reload: cover property (udl_wr ##[1:300] state_q == ST_COMMIT);
    c_state_fetch: cover property (o_se_load && state_q == ST_RUN);
    c_page_erase: cover property (erase_fire);

endmodule

/* File: sim/cdu_bus_master.sv */
// ------------------------------------------------------------
// Host side model: byte-level bus master
// ------------------------------------------------------------
module cdu_bus_master (
    input  wire logic       i_clk_sys,
    input  wire logic       i_ack,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_data,
    output logic            o_addr_valid,
    output logic [6:0]      o_addr,
    output logic            o_rnw,
    output logic            o_wr_valid,
    output logic [7:0]      o_wr_data,
    output logic            o_rd_req,
    output logic            o_stop
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ack_seen = 1'b0;
    logic [7:0] rd_byte  = 8'h00;
    // Idle bus at time zero
    initial begin
        {o_addr_valid, o_rnw, o_wr_valid, o_rd_req, o_stop} = '0;
        o_addr = '0;
        o_wr_data = '0;
    end
    // One strobe: 0 address, 1 write byte, 2 read, 3 stop
    task automatic strobe(input int k, input logic [7:0] v);
        @(negedge i_clk_sys);
        case (k)
            0: {o_addr, o_rnw, o_addr_valid} = {v, 1'b1};
            1: {o_wr_data, o_wr_valid} = {v, 1'b1};
            2: o_rd_req = 1'b1;
            default: o_stop = 1'b1;
        endcase
        ack_seen = 1'b0;
        // Stale read data must not pass for a fresh answer
        rd_byte = 8'hxx;
        // Answer may land one or two edges late
        for (int i = 0; i < 2; i++) begin
            @(negedge i_clk_sys);
            {o_addr_valid, o_wr_valid, o_rd_req, o_stop} = '0;
            ack_seen |= i_ack;
            if (i_rd_valid) rd_byte = i_rd_data;
        end
        // Released lines must not keep a stale value
        o_addr = ~o_addr;
        o_wr_data = ~o_wr_data;
    endtask
endmodule

/* File: sim/tb_top.sv */
module tb_top import cdu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] IDS [4] = '{8'h5a, 8'h11, 8'h3c, 8'hc3};
    logic        clk = 0, rstn = 0, sup = 0, ah = 0, al = 0, adv = 0;
    logic [5:0]  nst = '0;
    logic [7:0]  rd, a_v, b_v, c_v;
    logic [7:0]  cix = 8'h10;
    logic [31:0] rnd = 32'hac3b;
    int          error_cnt = 0, n_compared = 0, c;
    logic        av, rnw, wv, rq, sp, ack, rv, ld, rdy;
    logic [6:0]  ad;
    logic [7:0]  wd, rdd, cfg;
    logic [63:0] sw;
    // Free-running 250 MHz clock
    initial forever #2 clk = ~clk;
    cdu_top #(
        .SE_START_DELAY(20), .ID_MANUFACTURER(IDS[0]),
        .ID_REVISION(IDS[1]), .ID_BRAND_FIRST(IDS[2]),
        .ID_BRAND_SECOND(IDS[3])) dut_u (
        .i_clk_sys(clk), .i_resetn(rstn), .i_supply_ok(sup),
        .i_addr_select_high(ah), .i_addr_select_low(al),
        .i_bus_addr_valid(av), .i_bus_addr(ad), .i_bus_rnw(rnw),
        .i_bus_wr_valid(wv), .i_bus_wr_data(wd), .i_bus_rd_req(rq),
        .i_bus_stop(sp), .i_cfg_index(cix), .i_se_advance(adv),
        .i_se_next_state(nst), .o_bus_ack(ack), .o_bus_rd_valid(rv),
        .o_bus_rd_data(rdd), .o_cfg_data(cfg), .o_cfg_ready(rdy),
        .o_se_load(ld), .o_se_state_word(sw));
    cdu_bus_master bm (
        .i_clk_sys(clk), .i_ack(ack), .i_rd_valid(rv),
        .i_rd_data(rdd), .o_addr_valid(av), .o_addr(ad),
        .o_rnw(rnw), .o_wr_valid(wv), .o_wr_data(wd),
        .o_rd_req(rq), .o_stop(sp));
    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [6:0] sa(input logic h, input logic l);
        return {5'b01101, h, l};
    endfunction
    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Write session: n bytes, first one is the pointer
    task automatic xfer(input int n, input logic [23:0] b);
        bm.strobe(0, {sa(ah, al), 1'b0});
        for (int i = n - 1; i >= 0; i--) begin
            bm.strobe(1, b[i*8 +: 8]);
            chk("ack", 1, bm.ack_seen);
        end
        bm.strobe(3, 8'h00);
    endtask
    task automatic rreg(input int n, input logic [23:0] b);
        xfer(n, b);
        bm.strobe(0, {sa(ah, al), 1'b1});
        bm.strobe(2, 8'h00);
        rd = bm.rd_byte;
        bm.strobe(3, 8'h00);
    endtask
    // Bounded wait on ready (s=0) or engine load (s=1)
    task automatic wait_hi(input bit s, input int lim, output int n);
        n = 0;
        while ((s ? ld : rdy) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard, far beyond the expected run length
    initial begin
        #200us;
        error_cnt++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1;
        repeat (50) @(negedge clk);
        chk("ready", 0, rdy);
        sup = 1;
        bm.strobe(0, {sa(0, 0), 1'b0});
        chk("early ack", 0, bm.ack_seen);
        bm.strobe(3, 8'h00);
        wait_hi(0, 400, c);
        chk("fill", 1, c > 213 && c < 227);
        wait_hi(1, 2600, c);
        chk("first state", 1, c > 2514 && c < 2526);
        @(negedge clk);
        for (int i = 0; i < 2; i++) begin
            nst = i ? 6'h3f : 6'h01;
            adv = 1;
            @(negedge clk);
            adv = 0;
            wait_hi(1, 2600, c);
            chk("fetch", i ? 2600 : SE_FETCH_CYCLES, c);
            @(negedge clk);
        end
        for (int p = 0; p < 4; p++) begin
            ah = p[1];
            al = p[0];
            // Odd passes also spoil the top fixed address bit
            bm.strobe(0, {sa(ah, ~al) ^ {p[0], 6'h00}, 1'b0});
            chk("wrong addr", 0, bm.ack_seen);
            bm.strobe(3, 8'h00);
            xfer(1, 24'h90);
        end
        for (int i = 0; i < 5; i++) begin
            if (i == 4) xfer(2, 24'hf4a5);
            rreg(1, 24'(8'hf4 + i % 4));
            chk("id", IDS[i % 4], rd);
        end
        rnd = lfsr(rnd);
        a_v = rnd[7:0];
        b_v = ~a_v;
        rnd = lfsr(rnd);
        c_v = {~b_v[7], 1'b0, rnd[5:0]};
        xfer(2, 24'h9001);
        xfer(2, {8'h10, a_v});
        chk("live", a_v, cfg);
        xfer(2, 24'h9000);
        xfer(2, {8'h10, b_v});
        chk("staged", a_v, cfg);
        rreg(1, 24'h10);
        chk("stage rd", b_v, rd);
        xfer(2, 24'h9002);
        chk("commit", b_v, cfg);
        // Erase before program, as the host must
        xfer(2, 24'h9004);
        xfer(2, 24'hf810);
        xfer(1, 24'hfe);
        rreg(2, 24'hf810);
        chk("erased", 8'hff, rd);
        xfer(3, {16'hf810, c_v});
        xfer(3, {16'hf810, ~c_v});
        rreg(2, 24'hf810);
        chk("nv", c_v, rd);
        chk("kept", b_v, cfg);
        xfer(2, 24'h9000);
        xfer(2, 24'hf810);
        xfer(1, 24'hfe);
        rreg(2, 24'hf810);
        chk("no erase", c_v, rd);
        // Engine words live only in their own store
        xfer(2, 24'h9004);
        xfer(2, 24'hfa08);
        xfer(1, 24'hfe);
        xfer(3, {16'hfa08, c_v});
        nst = 6'h01;
        adv = 1;
        @(negedge clk);
        adv = 0;
        wait_hi(1, 2600, c);
        chk("word", {{7{ERASED_BYTE}}, c_v}, sw);
        xfer(2, 24'hd801);
        rd = 8'h01;
        for (int i = 0; i < 20 && rd[0] !== 1'b0; i++) rreg(1, 24'hd8);
        chk("dl done", 0, rd[0]);
        chk("reload", c_v, cfg);
        cix = 8'h00;
        @(negedge clk);
        chk("reload ff", ERASED_BYTE, cfg);
        cix = 8'he0;
        @(negedge clk);
        chk("cfg range", 0, cfg);
        finish_test();
    end
endmodule
